/* core/elic_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "elic_cfg.svh"

module elic_top (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  portAPinEvents,
  input  wire logic [5:0]  portBPinEvents,
  input  wire logic [7:0]  portCPinEvents,
  input  wire logic        mouseTxEvent,
  input  wire logic        mouseRxEvent,
  input  wire logic        mouseStopErrorEvent,
  input  wire logic        padTxEvent,
  input  wire logic        padRxEvent,
  input  wire logic        padStopErrorEvent,
  input  wire logic        syncSerialTxEvent,
  input  wire logic        syncSerialRxEvent,
  input  wire logic        syncSerialOverrunEvent,
  input  wire logic        audioTxBuf0Done,
  input  wire logic        audioRxBuf0Done,
  input  wire logic        audioTxBuf1Done,
  input  wire logic        audioRxBuf1Done,
  input  wire logic        audioTxThresholdEvent,
  input  wire logic        audioRxThresholdEvent,
  input  wire logic        audioTxUnderrunEvent,
  input  wire logic        audioRxOverrunEvent,
  input  wire logic        audioLinkSentEvent,
  input  wire logic        audioLinkReadDoneEvent,
  input  wire logic        audioStatusTimeoutEvent,
  input  wire logic        usbPowerSenseEvent,
  input  wire logic        hostCtrlMainEventN,
  input  wire logic        hostCtrlBufferAccessEvent,
  input  wire logic        hostCtrlRemoteWakeEvent,
  input  wire logic        hostCtrlFrameEventN,
  input  wire logic        usbPortResumeEvent,
  input  wire logic        socket0ReadyEvent,
  input  wire logic        socket1ReadyEvent,
  input  wire logic        socket0DetectEvent,
  input  wire logic        socket1DetectEvent,
  input  wire logic        socket0StatusChangeEvent,
  input  wire logic        socket1StatusChangeEvent,
  input  wire logic [63:0] edgeSelect,
  input  wire logic [63:0] sourceMask,
  input  wire logic [63:0] wakeEdgeSelect,
  input  wire logic [63:0] wakeEnable,
  input  wire logic        wakeModeSel,
  input  wire logic        testRawSel,
  input  wire logic [63:0] testRaw,
  input  wire logic        setStrobe,
  input  wire logic [63:0] setBits,
  input  wire logic        clearStrobe,
  input  wire logic [63:0] clearBits,
  input  wire logic        readClockEn,
  output logic             intOut,
  output logic      [63:0] latchedSource,
  output logic      [63:0] syncedSourceStatus,
  output logic             statusValid
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0]            rstSync_q;
  logic                  rstnSync;
  logic [63:0]           pinSources;
  logic [63:0]           rawSource;
  logic [63:0]           wakeLatched;
  logic [63:0]           setEffective;
  logic [63:0]           clearEffective;
  logic                  normalAny;
  logic                  wakeAny;
  elic_pkg::elic_mode_t  mode;
  elic_pkg::elic_top_t   st_q;
  elic_pkg::elic_top_t   st_d;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end

  assign rstnSync = rstSync_q[1];

  // ----------------------------------------------------------------
  // Source map
  // ----------------------------------------------------------------
  // Unused positions are tied low so they can never latch.
  assign pinSources = {
    9'h000,
    socket1StatusChangeEvent,
    socket0StatusChangeEvent,
    socket1DetectEvent,
    socket0DetectEvent,
    socket1ReadyEvent,
    socket0ReadyEvent,
    usbPortResumeEvent,
    hostCtrlFrameEventN,
    hostCtrlRemoteWakeEvent,
    hostCtrlBufferAccessEvent,
    hostCtrlMainEventN,
    usbPowerSenseEvent,
    audioStatusTimeoutEvent,
    audioLinkReadDoneEvent,
    audioLinkSentEvent,
    audioRxOverrunEvent,
    audioTxUnderrunEvent,
    audioRxThresholdEvent,
    audioTxThresholdEvent,
    audioRxBuf1Done,
    audioTxBuf1Done,
    audioRxBuf0Done,
    audioTxBuf0Done,
    5'h00,
    syncSerialOverrunEvent,
    syncSerialRxEvent,
    syncSerialTxEvent,
    padStopErrorEvent,
    padRxEvent,
    padTxEvent,
    mouseStopErrorEvent,
    mouseRxEvent,
    mouseTxEvent,
    portCPinEvents,
    portBPinEvents,
    portAPinEvents
  };

  // The test pattern replaces the pins ahead of the edge logic.
  assign rawSource = testRawSel ? (testRaw & `ELIC_VALID_MASK)
                                : pinSources;

  assign setEffective   = setStrobe ? setBits : `ELIC_LATCH_RST;
  assign clearEffective = clearStrobe ? clearBits : `ELIC_LATCH_RST;

  // ----------------------------------------------------------------
  // Edge latches
  // ----------------------------------------------------------------
  elic_edge_latch u_normalLatch (
    .clk     (clk),
    .rstn    (rstnSync),
    .rawIn   (rawSource),
    .fallSel (edgeSelect),
    .setBits (setEffective),
    .clrBits (clearEffective),
    .latched (latchedSource)
  );

  // Wake capture keeps its own edge choice and enable.
  elic_edge_latch u_wakeLatch (
    .clk     (clk),
    .rstn    (rstnSync),
    .rawIn   (rawSource),
    .fallSel (wakeEdgeSelect),
    .setBits (`ELIC_LATCH_RST),
    .clrBits (clearEffective),
    .latched (wakeLatched)
  );

  elic_status_sync u_statusSync (
    .clk       (clk),
    .rstn      (rstnSync),
    .readPulse (readClockEn),
    .latchedIn (latchedSource),
    .status    (syncedSourceStatus)
  );

  // ----------------------------------------------------------------
  // Output combine
  // ----------------------------------------------------------------
  assign mode = wakeModeSel ? elic_pkg::ELIC_WAKE
                            : elic_pkg::ELIC_NORMAL;

  assign normalAny = |(latchedSource & sourceMask
                       & `ELIC_VALID_MASK);
  assign wakeAny   = |(wakeLatched & wakeEnable
                       & `ELIC_VALID_MASK);

  // Pulling the pin low during a clear gives the host a fresh edge.
  always_comb begin
    intOut = 1'b0;
    if (!clearStrobe) begin
      case (mode)
        elic_pkg::ELIC_NORMAL: intOut = normalAny;
        elic_pkg::ELIC_WAKE:   intOut = wakeAny;
        default:               intOut = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status fill tracking
  // ----------------------------------------------------------------
  // Status is trusted after two read pulses with no set or clear.
  always_comb begin
    st_d = st_q;
    if (setStrobe || clearStrobe) begin
      st_d.fill = elic_pkg::ELIC_SYNC_EMPTY;
    end else if (readClockEn) begin
      case (st_q.fill)
        elic_pkg::ELIC_SYNC_EMPTY: st_d.fill = elic_pkg::ELIC_SYNC_HALF;
        elic_pkg::ELIC_SYNC_HALF:  st_d.fill = elic_pkg::ELIC_SYNC_FULL;
        elic_pkg::ELIC_SYNC_FULL:  st_d.fill = elic_pkg::ELIC_SYNC_FULL;
        default:                   st_d.fill = elic_pkg::ELIC_SYNC_EMPTY;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign statusValid = (st_q.fill == elic_pkg::ELIC_SYNC_FULL);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rstnSync);

  clear_holds_low_a: assert property (
    clearStrobe |-> !intOut
  ) else $error("Output high during a status clear.");

  normal_or_out_a: assert property (
    (!wakeModeSel && !clearStrobe)
      |-> (intOut == |(latchedSource & sourceMask))
  ) else $error("Normal output is not the masked OR.");

  wake_or_out_a: assert property (
    (wakeModeSel && !clearStrobe)
      |-> (intOut == |(wakeLatched & wakeEnable))
  ) else $error("Wake output is not the enabled OR.");

  clear_release_a: assert property (
    ($fell(clearStrobe) && !wakeModeSel
      && |(latchedSource & sourceMask)) |-> intOut
  ) else $error("Output did not return after clear.");

  rise_latches_a: assert property (
    ($rose(rawSource[`ELIC_POS_MOUSE]) && $past(rstnSync)
      && !edgeSelect[`ELIC_POS_MOUSE])
      |=> latchedSource[`ELIC_POS_MOUSE]
  ) else $error("Rising edge was not latched.");

  fall_latches_a: assert property (
    ($fell(rawSource[`ELIC_POS_PORTA]) && $past(rstnSync)
      && edgeSelect[`ELIC_POS_PORTA])
      |=> latchedSource[`ELIC_POS_PORTA]
  ) else $error("Falling edge was not latched.");

  no_wrong_edge_a: assert property (
    ($fell(rawSource[`ELIC_POS_PAD]) && !edgeSelect[`ELIC_POS_PAD]
      && !latchedSource[`ELIC_POS_PAD]
      && !(setStrobe && setBits[`ELIC_POS_PAD]))
      |=> !latchedSource[`ELIC_POS_PAD]
  ) else $error("Opposite edge set a latch.");

  set_wins_a: assert property (
    (setStrobe && setBits[`ELIC_POS_SSP])
      |=> latchedSource[`ELIC_POS_SSP]
  ) else $error("Software set was lost.");

  clear_one_a: assert property (
    (clearStrobe && clearBits[`ELIC_POS_USB]
      && !(setStrobe && setBits[`ELIC_POS_USB])
      && $stable(rawSource[`ELIC_POS_USB]))
      |=> !latchedSource[`ELIC_POS_USB]
  ) else $error("Clear did not drop the latch.");

  clear_zero_keeps_a: assert property (
    (latchedSource[`ELIC_POS_SOCKET]
      && !(clearStrobe && clearBits[`ELIC_POS_SOCKET]))
      |=> latchedSource[`ELIC_POS_SOCKET]
  ) else $error("Latch dropped without a clear.");

  reserved_zero_a: assert property (
    (latchedSource[31:27] == 5'h00)
      && (latchedSource[63:55] == 9'h000)
      && (syncedSourceStatus[63:55] == 9'h000)
  ) else $error("Reserved position is set.");

  mask_blocks_a: assert property (
    (!wakeModeSel && (sourceMask == `ELIC_MASK_RST)) |-> !intOut
  ) else $error("Masked sources drove the output.");

  two_read_sync_a: assert property (
    (readClockEn ##1 readClockEn) |=>
      (syncedSourceStatus
        == ($past(latchedSource, 2) & `ELIC_VALID_MASK))
  ) else $error("Status is not latched value after two reads.");

  status_hold_a: assert property (
    !readClockEn |=> $stable(syncedSourceStatus)
  ) else $error("Status moved without a read pulse.");

  fill_valid_a: assert property (
    (readClockEn && !setStrobe && !clearStrobe) ##1
      (readClockEn && !setStrobe && !clearStrobe) |=> statusValid
  ) else $error("Status not valid after two read pulses.");

  cover_normal_int_c: cover property (
    !wakeModeSel ##1 $rose(intOut)
  );

  cover_wake_int_c: cover property (
    wakeModeSel ##1 $rose(intOut)
  );

  cover_clear_edge_c: cover property (
    clearStrobe ##1 (!clearStrobe && intOut)
  );

  cover_status_ok_c: cover property (
    $rose(statusValid)
  );

endmodule
`default_nettype wire

/* core/elic_cfg.svh */
`ifndef ELIC_CFG_SVH
`define ELIC_CFG_SVH
// Contract
// - Normal and wake-up modes share one output.
// - Normal path: edge select, mask, set, clear.
// - Wake mode output is OR of enabled wakes.
// - Wake enable and edge kept apart from normal.
// - Each source latched on its selected edge.
// - No free clock; read pulse drives synchroniser.
// - Latched bits ORed onto the output.
// - Status passes two read-clocked sync stages.
// - Output formed combinationally from latched bits.
// - Output held low while clear strobe asserted.
// - Output returns high when clear ends, pending.
// - Port A 3:0, port B 9:4, port C 17:10.
// - Mouse events 18-20, trackpad events 21-23.
// - Serial port 24-26, sources 27-31 reserved.
// - Audio events occupy sources 32 to 42.
// - USB 43-48, sockets 49-54, 55-63 reserved.
// - One flat controller, per-bit edge control.
// - Port inputs accept rising or falling edge.
// - Chosen sources stay active while asleep.
// - Clear bit one clears; zero leaves unchanged.
// - Mask resets to zero; only enabled assert.
// - Edge bit zero rising, one falling.
// - Mode bit one wake, zero normal.

`define ELIC_NSRC       64
`define ELIC_VALID_MASK 64'h007f_ffff_07ff_ffff
`define ELIC_LATCH_RST  64'h0000_0000_0000_0000
`define ELIC_MASK_RST   64'h0000_0000_0000_0000
`define ELIC_EDGE_RST   64'h0000_0000_0000_0000
`define ELIC_SET1_BASE  32
`define ELIC_POS_PORTA  0
`define ELIC_POS_MOUSE  18
`define ELIC_POS_PAD    21
`define ELIC_POS_SSP    24
`define ELIC_POS_AUDIO  32
`define ELIC_POS_USB    43
`define ELIC_POS_SOCKET 49
`define ELIC_SYNC_READS 2

`endif

/* core/elic_pkg.sv */
`default_nettype none
package elic_pkg;

  typedef enum logic {
    ELIC_NORMAL,
    ELIC_WAKE
  } elic_mode_t;

  typedef enum logic [1:0] {
    ELIC_SYNC_EMPTY,
    ELIC_SYNC_HALF,
    ELIC_SYNC_FULL
  } elic_fill_t;

  typedef struct packed {
    logic        primed;
    logic [63:0] prevRaw;
    logic [63:0] latched;
  } elic_latch_t;

  typedef struct packed {
    logic [63:0] stage1;
    logic [63:0] stage2;
  } elic_sync_t;

  typedef struct packed {
    elic_fill_t fill;
  } elic_top_t;

endpackage
`default_nettype wire

/* core/elic_edge_latch.sv */
`timescale 1ns/100ps
`default_nettype none
`include "elic_cfg.svh"

module elic_edge_latch (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [63:0] rawIn,
  input  wire logic [63:0] fallSel,
  input  wire logic [63:0] setBits,
  input  wire logic [63:0] clrBits,
  output logic      [63:0] latched
);

  elic_pkg::elic_latch_t st_q;
  elic_pkg::elic_latch_t st_d;
  logic [63:0]           edgeHit;

  // Edges are only trusted once a previous sample exists after reset.
  always_comb begin
    st_d    = st_q;
    edgeHit = `ELIC_LATCH_RST;
    if (st_q.primed) begin
      edgeHit = (fallSel & st_q.prevRaw & ~rawIn)
              | (~fallSel & ~st_q.prevRaw & rawIn);
    end
    st_d.primed  = 1'b1;
    st_d.prevRaw = rawIn;
    // A new edge or set beats a clear in the same cycle.
    st_d.latched = ((st_q.latched & ~clrBits) | edgeHit | setBits)
                 & `ELIC_VALID_MASK;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign latched = st_q.latched;

endmodule
`default_nettype wire

/* core/elic_status_sync.sv */
`timescale 1ns/100ps
`default_nettype none
`include "elic_cfg.svh"

module elic_status_sync (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        readPulse,
  input  wire logic [63:0] latchedIn,
  output logic      [63:0] status
);

  elic_pkg::elic_sync_t st_q;
  elic_pkg::elic_sync_t st_d;

  // Both stages only move while the read clock is let through.
  always_comb begin
    st_d = st_q;
    if (readPulse) begin
      st_d.stage1 = latchedIn;
      st_d.stage2 = st_q.stage1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign status = st_q.stage2 & `ELIC_VALID_MASK;

endmodule
`default_nettype wire

/* dv/elic_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// --------
// Host input that reacts only to rising edges of the request line.
// --------
module elic_host_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic irqLine,
  output int        riseCount
);
  logic irqPrev_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqPrev_q <= 1'b0;
      riseCount <= 0;
    end else begin
      irqPrev_q <= irqLine;
      if (irqLine && !irqPrev_q) begin
        riseCount <= riseCount + 1;
      end
    end
  end
endmodule

`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "elic_cfg.svh"

module tb;
  localparam logic [63:0] VALID = `ELIC_VALID_MASK;
  logic        clk, rstn, wakeModeSel, testRawSel, run;
  logic        setStrobe, clearStrobe, readClockEn;
  logic        intOut, statusValid, mInt;
  logic [63:0] pins, edgeSelect, sourceMask, wakeEdgeSelect, wakeEnable;
  logic [63:0] testRaw, setBits, clearBits, latchedSource;
  logic [63:0] syncedSourceStatus, rawEff, nEdge, wEdge, clr;
  logic [63:0] mLat_q, mWake_q, mPrev_q, mS1_q, mS2_q;
  int          mFill_q, riseCount, nRise, nFail, totalChecks;

  // --------
  // Design and host.
  // --------
  elic_top uut (
    .clk(clk), .rstn(rstn),
    .portAPinEvents(pins[3:0]), .portBPinEvents(pins[9:4]),
    .portCPinEvents(pins[17:10]),
    .mouseTxEvent(pins[18]), .mouseRxEvent(pins[19]),
    .mouseStopErrorEvent(pins[20]), .padTxEvent(pins[21]),
    .padRxEvent(pins[22]), .padStopErrorEvent(pins[23]),
    .syncSerialTxEvent(pins[24]), .syncSerialRxEvent(pins[25]),
    .syncSerialOverrunEvent(pins[26]),
    .audioTxBuf0Done(pins[32]), .audioRxBuf0Done(pins[33]),
    .audioTxBuf1Done(pins[34]), .audioRxBuf1Done(pins[35]),
    .audioTxThresholdEvent(pins[36]), .audioRxThresholdEvent(pins[37]),
    .audioTxUnderrunEvent(pins[38]), .audioRxOverrunEvent(pins[39]),
    .audioLinkSentEvent(pins[40]), .audioLinkReadDoneEvent(pins[41]),
    .audioStatusTimeoutEvent(pins[42]), .usbPowerSenseEvent(pins[43]),
    .hostCtrlMainEventN(pins[44]), .hostCtrlBufferAccessEvent(pins[45]),
    .hostCtrlRemoteWakeEvent(pins[46]), .hostCtrlFrameEventN(pins[47]),
    .usbPortResumeEvent(pins[48]), .socket0ReadyEvent(pins[49]),
    .socket1ReadyEvent(pins[50]), .socket0DetectEvent(pins[51]),
    .socket1DetectEvent(pins[52]), .socket0StatusChangeEvent(pins[53]),
    .socket1StatusChangeEvent(pins[54]),
    .edgeSelect(edgeSelect), .sourceMask(sourceMask),
    .wakeEdgeSelect(wakeEdgeSelect), .wakeEnable(wakeEnable),
    .wakeModeSel(wakeModeSel), .testRawSel(testRawSel), .testRaw(testRaw),
    .setStrobe(setStrobe), .setBits(setBits), .clearStrobe(clearStrobe),
    .clearBits(clearBits), .readClockEn(readClockEn), .intOut(intOut),
    .latchedSource(latchedSource), .syncedSourceStatus(syncedSourceStatus),
    .statusValid(statusValid)
  );

  elic_host_model host (
    .clk(clk), .rstn(rstn), .irqLine(intOut), .riseCount(riseCount)
  );

  // --------
  // Reference model.
  // --------
  assign rawEff = (testRawSel ? testRaw : pins) & VALID;
  assign nEdge = VALID & ((rawEff & ~mPrev_q & ~edgeSelect) |
                          (~rawEff & mPrev_q & edgeSelect));
  assign wEdge = VALID & ((rawEff & ~mPrev_q & ~wakeEdgeSelect) |
                          (~rawEff & mPrev_q & wakeEdgeSelect));
  assign clr = clearStrobe ? clearBits : 64'h0;
  assign mInt = !clearStrobe && (wakeModeSel ? |(mWake_q & wakeEnable)
                                             : |(mLat_q & sourceMask));

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {mLat_q, mWake_q, mPrev_q, mS1_q, mS2_q} <= '0;
      mFill_q <= 0;
    end else begin
      mPrev_q <= rawEff;
      mLat_q <= ((mLat_q & ~clr) | (setStrobe ? setBits : 64'h0) | nEdge)
                & VALID;
      mWake_q <= ((mWake_q & ~clr) | wEdge) & VALID;
      if (readClockEn) begin
        mS1_q <= mLat_q;
        mS2_q <= mS1_q;
      end
      if (setStrobe || clearStrobe) begin
        mFill_q <= 0;
      end else if (readClockEn && mFill_q < 2) begin
        mFill_q <= mFill_q + 1;
      end
    end
  end

  // --------
  // Tests.
  // --------
  always #5 clk = ~clk;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic clearAll();
    clearStrobe = 1'b1;
    clearBits = '1;
    tick(1);
    clearStrobe = 1'b0;
    tick(1);
  endtask

  function automatic logic [63:0] rnd();
    return {$urandom, $urandom};
  endfunction

  task automatic finalReport();
    $display("checks=%0d failures=%0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(negedge clk) begin
    if (run) begin
      #4;
      chk(latchedSource, mLat_q);
      chk({63'h0, intOut}, {63'h0, mInt});
      chk(syncedSourceStatus, mS2_q);
      chk({63'h0, statusValid}, {63'h0, mFill_q == 2});
    end
  end

  initial begin
    #200000;
    nFail++;
    finalReport();
  end

  initial begin
    {clk, rstn, wakeModeSel, testRawSel, run} = '0;
    {setStrobe, clearStrobe, readClockEn} = '0;
    {pins, edgeSelect, sourceMask, wakeEdgeSelect, wakeEnable} = '0;
    {testRaw, setBits, clearBits} = '0;
    {nFail, totalChecks} = '0;
    void'($urandom(13144));
    tick(12);
    rstn = 1'b1;
    tick(4);
    chk(latchedSource, 64'h0);
    run = 1'b1;
    sourceMask = '1;
    for (int i = 0; i < 64; i++) begin
      pins[i] = 1'b1;
      tick(1);
      chk(latchedSource, VALID & (64'h1 << i));
      chk({63'h0, intOut}, {63'h0, VALID[i]});
      pins[i] = 1'b0;
      clearAll();
    end
    setStrobe = 1'b1;
    setBits = 64'h3;
    tick(1);
    setStrobe = 1'b0;
    tick(1);
    nRise = riseCount;
    clearStrobe = 1'b1;
    clearBits = 64'h1;
    repeat (3) begin
      tick(1);
      chk({63'h0, intOut}, 64'h0);
    end
    clearStrobe = 1'b0;
    #1 chk({63'h0, intOut}, 64'h1);
    tick(2);
    chk(64'(riseCount - nRise), 64'h1);
    chk(latchedSource, 64'h2);
    clearAll();
    edgeSelect[5] = 1'b1;
    pins[5] = 1'b1;
    tick(2);
    chk(latchedSource, 64'h0);
    pins[5] = 1'b0;
    tick(2);
    chk(latchedSource, 64'h20);
    edgeSelect[5] = 1'b0;
    clearAll();
    sourceMask = '0;
    wakeEnable = 64'h1 << 20;
    wakeEdgeSelect = 64'h1 << 20;
    wakeModeSel = 1'b1;
    pins[20] = 1'b1;
    tick(2);
    chk({63'h0, intOut}, 64'h0);
    chk(latchedSource, 64'h1 << 20);
    pins[20] = 1'b0;
    tick(2);
    chk({63'h0, intOut}, 64'h1);
    wakeModeSel = 1'b0;
    #1 chk({63'h0, intOut}, 64'h0);
    clearAll();
    setStrobe = 1'b1;
    setBits = 64'h0000_0001_0000_0001;
    tick(1);
    setStrobe = 1'b0;
    readClockEn = 1'b1;
    tick(2);
    readClockEn = 1'b0;
    chk(syncedSourceStatus, 64'h0000_0001_0000_0001);
    for (int c = 0; c < 3000; c++) begin
      pins = pins ^ (rnd() & rnd() & rnd());
      if ($urandom % 64 == 0)
        edgeSelect = rnd() & 64'h0000_0000_0003_ffff;
      if ($urandom % 64 == 0) sourceMask = rnd();
      if ($urandom % 64 == 0) wakeEdgeSelect = rnd();
      if ($urandom % 64 == 0) wakeEnable = rnd();
      if ($urandom % 50 == 0) wakeModeSel = ~wakeModeSel;
      if ($urandom % 100 == 0) testRawSel = ~testRawSel;
      testRaw = testRaw ^ (rnd() & rnd());
      setStrobe = ($urandom % 8 == 0);
      setBits = rnd() & rnd() & rnd();
      clearStrobe = ($urandom % 6 == 0);
      clearBits = rnd();
      readClockEn = !setStrobe && !clearStrobe && $urandom % 2;
      tick(1);
    end
    finalReport();
  end
endmodule

`default_nettype wire
